// ===== rtl/sample_sequencer.sv
`timescale 1ns/1ps
module sample_sequencer
  import sequencer_pkg::*;
#(
  parameter int CONV_DIVIDE = CONV_DIV,
  parameter int EDGES_PER_CH = CH_EDGES
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                sample_start_n_i,
  input  wire logic                select_n_i,
  input  wire logic                read_n_i,
  input  wire logic [RESULT_W-1:0] core_result_i,
  output logic                     hold_o,
  output logic      [1:0]          core_channel_o,
  output logic                     core_start_o,
  output logic                     done_n_o,
  output logic      [RESULT_W-1:0] data_o,
  output logic                     data_oe_o
);
  // Buffer word width and fixed sequence points
  localparam int RW = $bits(result_t);
  localparam logic [1:0] LAST_CH = 2'(CHANNELS - 1);
  localparam logic [7:0] DIV_LAST = 8'(CONV_DIVIDE - 1);
  localparam logic [7:0] CH_LAST = 8'(EDGES_PER_CH - 1);
  // Lead-in ticks before channel one, so a full run spans the documented edge count
  localparam logic [7:0] LEAD_LAST = 8'(SEQ_EDGES - CHANNELS * CH_EDGES - 1);

  // Whole block state, registered as one word
  typedef struct packed {
    seq_state_t                         st;
    logic                               start_q;
    logic                               read_q;
    logic [7:0]                         div;
    logic [7:0]                         edges;
    logic [1:0]                         channel;
    logic [CHANNELS-1:0][RESULT_W-1:0]  bank;
    logic [1:0]                         ptr;
    logic                               first_read;
    logic                               hold;
    logic                               core_start;
    logic                               done_n;
    logic [RESULT_W-1:0]                data;
    logic                               data_oe;
  } seq_reg_t;

  // Power-up contents: idle, tracking, flag high, strobes at idle level
  localparam seq_reg_t SEQ_RESET = '{
    st:         ST_IDLE,
    start_q:    1'b1,
    read_q:     1'b0,
    div:        8'h00,
    edges:      8'h00,
    channel:    2'h0,
    bank:       '0,
    ptr:        2'h0,
    first_read: 1'b0,
    hold:       1'b0,
    core_start: 1'b0,
    done_n:     1'b1,
    data:       '0,
    data_oe:    1'b0
  };

  // Index of the next channel or result register
  function automatic logic [1:0] next_index(input logic [1:0] idx);
    return idx + 2'h1;
  endfunction

  // Level edges from the value held at the previous clock edge
  function automatic logic rose_now(input logic prev, input logic curr);
    return !prev && curr;
  endfunction

  function automatic logic fell_now(input logic prev, input logic curr);
    return prev && !curr;
  endfunction

  // State, buffer handshake and strobe qualifiers
  seq_reg_t state_reg;
  seq_reg_t state_next;
  logic     fifo_in_valid;
  logic     fifo_in_ready;
  result_t  fifo_in;
  logic     fifo_out_valid;
  result_t  fifo_out;
  logic     conv_tick;
  logic     read_active;
  logic     start_rise;
  logic     read_begin;
  logic     read_end;
  logic     bank_settled;

  // Results pass through a small buffer before landing in the data bank
  result_fifo #(
    .WIDTH (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out)
  );

  // Converter clock enable and read qualifier
  assign conv_tick   = state_reg.div == DIV_LAST;
  assign read_active = !select_n_i && !read_n_i;

  // Strobe edges against the levels seen at the last clock edge
  assign start_rise = rose_now(state_reg.start_q, sample_start_n_i);
  assign read_begin = rose_now(state_reg.read_q, read_active);
  assign read_end   = fell_now(state_reg.read_q, read_active);

  // Result of the channel under conversion, queued at its last tick
  assign fifo_in.channel = state_reg.channel;
  assign fifo_in.code    = core_result_i;
  assign fifo_in_valid   = (state_reg.st == ST_CONV) && conv_tick
                           && (state_reg.edges == CH_LAST);

  // Last result has left the buffer and sits in the bank
  assign bank_settled = (state_reg.st == ST_DONE) && state_reg.hold && !fifo_out_valid;

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.start_q    = sample_start_n_i;
    state_next.read_q     = read_active;
    state_next.core_start = 1'b0;
    state_next.div = conv_tick ? 8'h00 : state_reg.div + 8'h01;

    // Completed results stored into the channel's own register
    if (fifo_out_valid) begin
      state_next.bank[fifo_out.channel] = fifo_out.code;
    end

    case (state_reg.st)
      ST_IDLE, ST_DONE: begin
        // Start edge taken on any clock phase; ignored while a result is pending
        if (start_rise && !(state_reg.st == ST_DONE && state_reg.hold)) begin
          state_next.st         = ST_SYNC;
          state_next.hold       = 1'b1;
          state_next.ptr        = 2'h0;
          state_next.channel    = 2'h0;
          state_next.edges      = 8'h00;
          state_next.first_read = 1'b0;
        end
      end
      ST_SYNC: begin
        // Lead-in ticks align channel one to the converter clock
        if (conv_tick) begin
          if (state_reg.edges == LEAD_LAST) begin
            state_next.st         = ST_CONV;
            state_next.edges      = 8'h00;
            state_next.core_start = 1'b1;
          end else begin
            state_next.edges = state_reg.edges + 8'h01;
          end
        end
      end
      ST_CONV: begin
        // Channel ends after its tick budget; next one starts once queued
        if (conv_tick) begin
          if (fifo_in_valid && fifo_in_ready) begin
            state_next.edges = 8'h00;
            if (state_reg.channel == LAST_CH) begin
              state_next.st = ST_DONE;
            end else begin
              state_next.channel    = next_index(state_reg.channel);
              state_next.core_start = 1'b1;
            end
          end else if (!fifo_in_valid) begin
            state_next.edges = state_reg.edges + 8'h01;
          end
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase

    // Flag low once last result lands in the bank
    if (bank_settled) begin
      state_next.hold       = 1'b0;
      state_next.done_n     = 1'b0;
      state_next.first_read = 1'b1;
    end

    // Read data: pointed register, shown one cycle behind the strobes
    state_next.data_oe = read_active;
    state_next.data    = state_reg.bank[state_reg.ptr];

    // First read after a sequence returns the flag high
    if (read_begin && state_reg.first_read) begin
      state_next.done_n     = 1'b1;
      state_next.first_read = 1'b0;
    end

    // Pointer steps at the end of each read and parks on the last register
    if (read_end && state_reg.ptr != LAST_CH) begin
      state_next.ptr = next_index(state_reg.ptr);
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= SEQ_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign hold_o         = state_reg.hold;
  assign core_channel_o = state_reg.channel;
  assign core_start_o   = state_reg.core_start;
  assign done_n_o       = state_reg.done_n;
  assign data_o         = state_reg.data;
  assign data_oe_o      = state_reg.data_oe;
endmodule // sample_sequencer

// ===== rtl/sequencer_pkg.sv
package sequencer_pkg;
  localparam int RESULT_W      = 12;
  localparam int CHANNELS      = 4;
  localparam int CLK_HZ        = 40_000_000;
  localparam int CONV_CLK_HZ   = 2_500_000;
  localparam int CONV_DIV      = CLK_HZ / CONV_CLK_HZ;
  localparam int SEQ_EDGES     = 78;
  localparam int CH_EDGES      = SEQ_EDGES / CHANNELS;
  localparam int FIFO_DEPTH    = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SYNC = 4'h2,
    ST_CONV = 4'h4,
    ST_DONE = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [1:0]          channel;
    logic [RESULT_W-1:0] code;
  } result_t;
endpackage

// ===== rtl/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic        push;
  logic        pop;

  // Handshakes and pointer advance
  always_comb begin
    state_next = state_reg;
    push = in_valid_i && (state_reg.count != (AW+1)'(DEPTH));
    pop  = out_ready_i && (state_reg.count != '0);
    if (push) begin
      state_next.mem[state_reg.wr] = in_data_i;
      state_next.wr = (state_reg.wr == AW'(DEPTH-1)) ? '0 : state_reg.wr + 1'b1;
    end
    if (pop) begin
      state_next.rd = (state_reg.rd == AW'(DEPTH-1)) ? '0 : state_reg.rd + 1'b1;
    end
    state_next.count = state_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_ready_o  = state_reg.count != (AW+1)'(DEPTH);
  assign out_valid_o = state_reg.count != '0;
  assign out_data_o  = state_reg.mem[state_reg.rd];
endmodule // result_fifo

// ===== tb/sequencer_sva.sv
`timescale 1ns/1ps
module sequencer_sva #(
  parameter int CONV_DIVIDE  = 16,
  parameter int EDGES_PER_CH = 19
) (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       sample_start_n_i,
  input wire logic       select_n_i,
  input wire logic       read_n_i,
  input wire logic       hold_o,
  input wire logic [1:0] core_channel_o,
  input wire logic       core_start_o,
  input wire logic       done_n_o,
  input wire logic       data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  localparam int TICKS = CONV_DIVIDE * 4 * EDGES_PER_CH;
  int busy_cnt;
  // Length of the running sequence
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) busy_cnt <= 0;
    else busy_cnt <= (hold_o && done_n_o) ? busy_cnt + 1 : 0;
  end
  property p_hold_on; $rose(sample_start_n_i) && !hold_o |=> hold_o; endproperty
  property p_hold_keep; hold_o && done_n_o |=> hold_o || !done_n_o; endproperty
  property p_ch_step;
    hold_o && $past(hold_o) && $changed(core_channel_o)
      |-> core_channel_o == $past(core_channel_o) + 2'h1;
  endproperty
  property p_first;
    $rose(hold_o) |-> ##[0:40] (core_start_o && core_channel_o == 2'h0);
  endproperty
  property p_pulse; core_start_o |=> !core_start_o; endproperty
  property p_done_len;
    $fell(done_n_o) |-> busy_cnt >= TICKS && busy_cnt <= TICKS + 4 * CONV_DIVIDE;
  endproperty
  property p_done_clr; !done_n_o && !select_n_i && !read_n_i |-> ##[1:2] done_n_o; endproperty
  property p_oe; data_oe_o == !($past(select_n_i) || $past(read_n_i)); endproperty
  a_hold_on: assert property (p_hold_on) else $error("hold missed");
  a_hold_keep: assert property (p_hold_keep) else $error("hold dropped");
  a_ch_step: assert property (p_ch_step) else $error("channel order");
  a_first: assert property (p_first) else $error("first channel");
  a_pulse: assert property (p_pulse) else $error("start pulse");
  a_done_len: assert property (p_done_len) else $error("sequence length");
  a_done_clr: assert property (p_done_clr) else $error("flag not cleared");
  a_oe: assert property (p_oe) else $error("data enable");
  c_seq: cover property ($fell(done_n_o));
  c_read: cover property ($rose(data_oe_o) && done_n_o);
  c_start: cover property ($rose(hold_o));
endmodule // sequencer_sva

bind sample_sequencer sequencer_sva #(
  .CONV_DIVIDE(CONV_DIVIDE), .EDGES_PER_CH(EDGES_PER_CH)) i_sva (
  .clk_i(clk_i), .reset_i(reset_i), .sample_start_n_i(sample_start_n_i),
  .select_n_i(select_n_i), .read_n_i(read_n_i), .hold_o(hold_o),
  .core_channel_o(core_channel_o), .core_start_o(core_start_o),
  .done_n_o(done_n_o), .data_oe_o(data_oe_o));

// ===== tb/core_stub.sv
`timescale 1ns/1ps
module core_stub
  import sequencer_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  hold_i,
  input  wire logic [1:0]            channel_i,
  input  wire logic [4*RESULT_W-1:0] codes_i,
  output logic      [RESULT_W-1:0]   result_o
);
  // Held sample of the chosen channel, churning while tracking
  always_ff @(posedge clk_i) begin
    result_o <= hold_i ? codes_i[channel_i*RESULT_W +: RESULT_W] : ~result_o;
  end
endmodule // core_stub

// ===== tb/four_channel_sample_sequencer_bench.sv
`timescale 1ns/1ps
module four_channel_sample_sequencer_bench;
  import sequencer_pkg::*;
  logic clk_i = 0, reset_i = 1, start_n = 1, sel_n = 1, rd_n = 1;
  logic hold, cstart, done_n, oe;
  logic [1:0] ch;
  logic [RESULT_W-1:0] res, data;
  logic [4*RESULT_W-1:0] codes = '0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  localparam int SIM_EDGES = 2;

  always #12.5 clk_i = ~clk_i;

  sample_sequencer #(.EDGES_PER_CH(SIM_EDGES)) i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .sample_start_n_i(start_n),
    .select_n_i(sel_n), .read_n_i(rd_n), .core_result_i(res),
    .hold_o(hold), .core_channel_o(ch), .core_start_o(cstart),
    .done_n_o(done_n), .data_o(data), .data_oe_o(oe));
  core_stub i_core (.clk_i(clk_i), .hold_i(hold), .channel_i(ch),
    .codes_i(codes), .result_o(res));

  task stop_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task tick(int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task chk(string nm, logic [11:0] e, logic [11:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  function logic [RESULT_W-1:0] exp_word(int k);
    return codes[k*RESULT_W +: RESULT_W];
  endfunction
  // Clock edges of a full run less one converter tick: lead-in plus channel ticks
  function int seq_lo();
    return (SEQ_EDGES - CHANNELS * CH_EDGES + CHANNELS * SIM_EDGES - 1) * CONV_DIV;
  endfunction
  // One host read, k picks the expected register
  task rd(int k);
    sel_n = 0;
    rd_n = 0;
    tick(2);
    chk("data", exp_word(k), data);
    chk("oe", 12'h1, oe);
    chk("done", 12'h1, done_n);
    sel_n = 1;
    rd_n = 1;
    tick(2);
  endtask
  // Start strobe of random width, then wait for completion
  task conv();
    int w;
    w = $urandom_range(4, 1);
    start_n = 0;
    tick(w);
    start_n = 1;
    tick(2);
    chk("hold", 12'h1, hold);
    // No new start and no read until the flag falls
    for (w = 0; w < 2000 && done_n !== 1'b0; w++) tick(1);
    chk("done", 12'h0, done_n);
    chk("hold", 12'h0, hold);
    cmp_count++;
    if (w + 1 < seq_lo() || w + 1 > seq_lo() + CONV_DIV + 2) begin
      n_mismatch++;
      $display("unexpected seq_cycles exp %0d..%0d got %0d", seq_lo(), seq_lo() + CONV_DIV + 2,
               w + 1);
    end
  endtask

  initial begin
    void'($urandom(36801));
    tick(20);
    reset_i = 0;
    tick(2);
    for (int s = 0; s < 8; s++) begin
      codes = {16'($urandom), $urandom};
      if (s == 0) codes = {12'h7FF, 12'h800, 12'hFFF, 12'h000};
      conv();
      // Every third run stops after two reads to test the pointer reset
      for (int k = 0; k < 4; k++) if (s % 3 != 1 || k < 2) rd(k);
      if (s % 3 == 2) rd(3);
    end
    stop_test;
  end
endmodule // four_channel_sample_sequencer_bench
